/* rtl/phy_control_pkg.sv */
// Package: addresses, field positions, reset values and types for the PHY control register
package phy_control_pkg;

    localparam logic [4:0]  PHY_CONTROL_ADDR   = 5'h00;    // Management address of the control register
    localparam logic [15:0] PHY_CONTROL_RESET  = 16'h3100; // Value after reset
    localparam logic [15:0] PHY_CONTROL_WMASK  = 16'hFF80; // Writable bits, low seven reserved

    localparam int BIT_REG_RESET      = 15;  // Self-clearing register reset
    localparam int BIT_LOOPBACK       = 14;  // Loopback enable
    localparam int BIT_SPEED          = 13;  // Speed select, one is 100 Mb/s
    localparam int BIT_NEG_ENABLE     = 12;  // Auto-negotiation enable
    localparam int BIT_LOW_POWER      = 11;  // Low-power state
    localparam int BIT_ISOLATE        = 10;  // Isolate data paths
    localparam int BIT_RESTART_NEG    = 9;   // Self-clearing negotiation restart
    localparam int BIT_DUPLEX         = 8;   // Full duplex when set
    localparam int BIT_COLLISION_TEST = 7;   // Collision test enable

    // Configuration levels presented to the PHY core
    typedef struct packed {
        logic loopback_enable;
        logic speed_select;
        logic negotiation_enable;
        logic low_power_enable;
        logic isolate_enable;
        logic full_duplex;
        logic collision_test_enable;
    } phy_config_s;

    // Self-clearing command sequencing
    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_BUSY
    } cmd_state_e;

endpackage

/* rtl/phy_control_register.sv */
// PHY control register at management address zero, with self-clearing commands and collision test
`timescale 1ns/100ps

// Overview
// One 16-bit control word holds the PHY configuration and two commands.
// Writes arrive as a single-cycle strobe with a five-bit address; only
// address zero is mapped and any other address is dropped silently.
// The low seven bits are reserved: they are masked on every write, so
// they can never be stored and always read back as zero.
// The configuration fields leave the block as one packed struct, launched
// from flops so the PHY core sees clean levels.
// After reset the word reads 0x3100: 100 Mb/s, negotiation on, full
// duplex, no loopback, no power saving, no isolation, no test mode, so
// the PHY runs normally without any software set-up.
// Bit 15 asks for a register reset and bit 9 for a negotiation restart.
// Each starts a small sequencer that raises a request toward the PHY core
// and waits for the matching done pulse. While a command is pending its
// bit stays set, even if software writes zero over it, so the bit always
// tells the truth about the request.
// A completed register reset puts the whole word back to its reset value
// and also drops a pending negotiation restart.
// A restart written in the very cycle its predecessor completes keeps the
// bit set and the request raised: the new write wins over the clear.
// Collision test mode mirrors the transmit activity onto the collision
// output one cycle later, so a MAC can check its collision handling.
// Read data is not addressed: it always shows this register.

// What this block does
// [RQ1] Register at address zero, resets to 0x3100
// [RQ2] Reset defaults give normal operation unconfigured
// [RQ3] Bit seven enables collision test mode
// [RQ4] Collision test: collision follows active transmission
// [RQ5] Bits six to zero read zero, reset zero
// [RQ6] Reset and restart bits self-clear after action
module phy_control_register (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          mgmt_write,
    input  wire logic [4:0]                    mgmt_addr,
    input  wire logic [15:0]                   mgmt_wdata,
    input  wire logic                          tx_active,
    input  wire logic                          reg_reset_done,
    input  wire logic                          negotiation_restart_done,
    output logic      [15:0]                   mgmt_rdata,
    output phy_control_pkg::phy_config_s       phy_config,
    output logic                               reg_reset_request,
    output logic                               negotiation_restart_request,
    output logic                               collision_indication
);

    logic [15:0]                  control_ff;      // Stored register value
    logic [15:0]                  nxt_control;     // Next register value
    phy_control_pkg::cmd_state_e  rst_state_ff;    // Register reset sequencer
    phy_control_pkg::cmd_state_e  nxt_rst_state;
    phy_control_pkg::cmd_state_e  neg_state_ff;    // Negotiation restart sequencer
    phy_control_pkg::cmd_state_e  nxt_neg_state;
    logic [15:0]                  mgmt_rdata_ff;   // Registered read data
    phy_control_pkg::phy_config_s phy_config_ff;   // Registered configuration
    logic                         coll_ff;         // Registered collision indication
    logic                         rst_req_ff;      // Registered register reset request
    logic                         neg_req_ff;      // Registered negotiation restart request

    // Write decode
    // Strobe and address qualify every write; data is masked first
    wire   hit_write   = mgmt_write && (mgmt_addr == phy_control_pkg::PHY_CONTROL_ADDR); // RQ1
    // Reserved bits never stored, so they always read zero
    wire [15:0] write_value = mgmt_wdata & phy_control_pkg::PHY_CONTROL_WMASK; // RQ5
    wire   start_rst   = hit_write && write_value[phy_control_pkg::BIT_REG_RESET];
    wire   start_neg   = hit_write && write_value[phy_control_pkg::BIT_RESTART_NEG];
    wire   rst_finish  = (rst_state_ff == phy_control_pkg::CMD_BUSY) && reg_reset_done;
    wire   neg_finish  = (neg_state_ff == phy_control_pkg::CMD_BUSY) && negotiation_restart_done;

    // Sequencer occupancy, used to hold a pending command bit
    wire   rst_busy    = (rst_state_ff == phy_control_pkg::CMD_BUSY);
    wire   neg_busy    = (neg_state_ff == phy_control_pkg::CMD_BUSY);

    // Next register value: write, then self-clear on completion
    // Priority from low to high: hold, write, pending hold, completion.
    // Completion comes last so a finished command always clears its bit,
    // and the restart clear yields to a restart written in the same cycle.
    always_comb begin
        nxt_control = control_ff;
        if (hit_write) begin
            nxt_control = write_value;
        end
        // A pending command bit survives a write of zero
        if (rst_busy) begin
            nxt_control[phy_control_pkg::BIT_REG_RESET] = 1'b1; // RQ6
        end
        if (neg_busy) begin
            nxt_control[phy_control_pkg::BIT_RESTART_NEG] = 1'b1; // RQ6
        end
        if (rst_finish) begin
            // Register reset returns every field to default, bit 15 cleared
            nxt_control = phy_control_pkg::PHY_CONTROL_RESET; // RQ6
        end else if (neg_finish && !start_neg) begin
            // New restart written in the finishing cycle keeps the bit set
            nxt_control[phy_control_pkg::BIT_RESTART_NEG] = 1'b0; // RQ6
        end
    end

    // Register reset sequencer
    // Busy from the write that sets bit 15 until the core reports done;
    // a second reset written while busy simply merges into the first.
    always_comb begin
        nxt_rst_state = rst_state_ff;
        case (rst_state_ff)
            // Waiting for a reset command
            phy_control_pkg::CMD_IDLE: begin
                if (start_rst) begin
                    nxt_rst_state = phy_control_pkg::CMD_BUSY;
                end
            end
            // Request raised until the core finishes
            phy_control_pkg::CMD_BUSY: begin
                if (reg_reset_done) begin
                    nxt_rst_state = phy_control_pkg::CMD_IDLE;
                end
            end
            // Unused code falls back to idle
            default: begin
                nxt_rst_state = phy_control_pkg::CMD_IDLE;
            end
        endcase
    end

    // Negotiation restart sequencer; a register reset cancels it
    // A restart written as a register reset completes is dropped, since
    // the reset word clears bit 9 in that same cycle.
    always_comb begin
        nxt_neg_state = neg_state_ff;
        case (neg_state_ff)
            // Waiting for a restart command
            phy_control_pkg::CMD_IDLE: begin
                if (start_neg && !rst_finish) begin
                    nxt_neg_state = phy_control_pkg::CMD_BUSY;
                end
            end
            // Request raised until done with no fresh restart, or until a reset completes
            phy_control_pkg::CMD_BUSY: begin
                if (rst_finish) begin
                    nxt_neg_state = phy_control_pkg::CMD_IDLE;
                end else if (negotiation_restart_done && !start_neg) begin
                    nxt_neg_state = phy_control_pkg::CMD_IDLE;
                end
            end
            // Unused code falls back to idle
            default: begin
                nxt_neg_state = phy_control_pkg::CMD_IDLE;
            end
        endcase
    end

    // Configuration levels from the next register value
    wire phy_control_pkg::phy_config_s nxt_config = '{
        loopback_enable:       nxt_control[phy_control_pkg::BIT_LOOPBACK],
        speed_select:          nxt_control[phy_control_pkg::BIT_SPEED],
        negotiation_enable:    nxt_control[phy_control_pkg::BIT_NEG_ENABLE],
        low_power_enable:      nxt_control[phy_control_pkg::BIT_LOW_POWER],
        isolate_enable:        nxt_control[phy_control_pkg::BIT_ISOLATE],
        full_duplex:           nxt_control[phy_control_pkg::BIT_DUPLEX],
        collision_test_enable: nxt_control[phy_control_pkg::BIT_COLLISION_TEST] // RQ3
    };

    // Collision raised while a transmission runs in test mode
    // Uses the stored bit, so a write that enables the test acts from the
    // next cycle; the output drops one cycle after transmission stops.
    wire nxt_coll = control_ff[phy_control_pkg::BIT_COLLISION_TEST] && tx_active; // RQ4

    // Request levels follow the sequencers' next state, from their own flops
    wire nxt_rst_req = (nxt_rst_state == phy_control_pkg::CMD_BUSY); // RQ6
    wire nxt_neg_req = (nxt_neg_state == phy_control_pkg::CMD_BUSY); // RQ6

    // Reset config is speed 100, negotiation on, full duplex: normal operation
    // Built from the package reset word so the two can never disagree
    localparam phy_control_pkg::phy_config_s CONFIG_RESET = '{
        loopback_enable:       phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_LOOPBACK],
        speed_select:          phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_SPEED],
        negotiation_enable:    phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_NEG_ENABLE],
        low_power_enable:      phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_LOW_POWER],
        isolate_enable:        phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_ISOLATE],
        full_duplex:           phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_DUPLEX],
        collision_test_enable: phy_control_pkg::PHY_CONTROL_RESET[phy_control_pkg::BIT_COLLISION_TEST]
    };

    // Register state
    // Word and sequencers move together on every edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            control_ff    <= phy_control_pkg::PHY_CONTROL_RESET; // RQ1
            rst_state_ff  <= phy_control_pkg::CMD_IDLE;
            neg_state_ff  <= phy_control_pkg::CMD_IDLE;
        end else begin
            control_ff    <= nxt_control;
            rst_state_ff  <= nxt_rst_state;
            neg_state_ff  <= nxt_neg_state;
        end
    end

    // Output flops
    // Every output is launched here, in step with the register word
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata_ff <= phy_control_pkg::PHY_CONTROL_RESET;
            phy_config_ff <= CONFIG_RESET; // RQ2
            coll_ff       <= 1'b0; // RQ3
            rst_req_ff    <= 1'b0;
            neg_req_ff    <= 1'b0;
        end else begin
            mgmt_rdata_ff <= nxt_control;
            phy_config_ff <= nxt_config;
            coll_ff       <= nxt_coll;
            rst_req_ff    <= nxt_rst_req;
            neg_req_ff    <= nxt_neg_req;
        end
    end

    // Drive outputs from flops
    // Plain wiring only, no logic between a flop and its pin
    assign mgmt_rdata                  = mgmt_rdata_ff;
    assign phy_config                  = phy_config_ff;
    assign reg_reset_request           = rst_req_ff;
    assign negotiation_restart_request = neg_req_ff;
    assign collision_indication        = coll_ff;

endmodule

/* tb/phy_control_register_bench.sv */
// Self-checking bench for the PHY control register
`timescale 1ns/100ps
module phy_control_register_bench;
    logic clock = 1'b0, rst_n = 1'b0, mgmt_write = 1'b0, tx_active = 1'b0, slow = 1'b0; // Bench drives
    logic [4:0]  mgmt_addr  = 5'h00;                 // Register address
    logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata;  // Write and read words
    logic reg_reset_request, negotiation_restart_request, collision_indication, reg_reset_done, negotiation_restart_done;
    phy_control_pkg::phy_config_s phy_config;       // Configuration levels
    int failures = 0, n_tests = 0;                   // Counters
    phy_control_register i_dut (.clock(clock), .rst_n(rst_n), .mgmt_write(mgmt_write), .mgmt_addr(mgmt_addr),
        .mgmt_wdata(mgmt_wdata), .tx_active(tx_active), .reg_reset_done(reg_reset_done),
        .negotiation_restart_done(negotiation_restart_done), .mgmt_rdata(mgmt_rdata), .phy_config(phy_config),
        .reg_reset_request(reg_reset_request), .negotiation_restart_request(negotiation_restart_request),
        .collision_indication(collision_indication));
    phy_core_model i_core (.clock(clock), .rst_n(rst_n), .slow(slow), .reg_reset_request(reg_reset_request),
        .negotiation_restart_request(negotiation_restart_request), .reg_reset_done(reg_reset_done),
        .negotiation_restart_done(negotiation_restart_done));
    initial forever #2 clock = ~clock;
    task automatic check(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic test_done;
        $display("%0d compares, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Present one write, left raised so writes may follow back to back
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clock);
        mgmt_write = 1'b1;
        mgmt_addr  = a;
        mgmt_wdata = d;
    endtask
    task automatic idle;
        @(negedge clock);
        mgmt_write = 1'b0;
    endtask
    task automatic t_reset;
        check(phy_control_pkg::PHY_CONTROL_RESET, mgmt_rdata);
        check(16'h0032, {9'h000, phy_config});
        check(16'h0000, {13'h0000, reg_reset_request, negotiation_restart_request, collision_indication});
        $display("reset test done");
    endtask
    task automatic t_write;
        wr(5'h00, 16'h4C7F);
        wr(5'h03, 16'hFFFF);
        idle;
        check(16'h4C00, mgmt_rdata);
        check(16'h004C, {9'h000, phy_config});
        $display("write test done");
    endtask
    task automatic t_collision;
        for (int on = 1; on >= 0; on--) begin
            wr(5'h00, on ? 16'h3180 : 16'h3100);
            idle;
            tx_active = 1'b1;
            @(negedge clock);
            check({15'h0000, on[0]}, {15'h0000, collision_indication});
            tx_active = 1'b0;
            @(negedge clock);
            check(16'h0000, {15'h0000, collision_indication});
        end
        $display("collision test done");
    endtask
    task automatic t_commands;
        logic [15:0] cmd [2] = '{16'h3300, 16'hC280};
        for (int k = 0; k < 2; k++) begin
            slow = k[0] ? 1'b0 : 1'b1;
            wr(5'h00, cmd[k]);
            idle;
            check({14'h0000, cmd[k][15], cmd[k][9]}, {14'h0000, reg_reset_request, negotiation_restart_request});
            wr(5'h00, 16'h3100);
            idle;
            check({14'h0000, cmd[k][15], cmd[k][9]}, {14'h0000, reg_reset_request, negotiation_restart_request});
            for (int i = 0; i < 64 && (reg_reset_request !== 1'b0 || negotiation_restart_request !== 1'b0); i++)
                @(negedge clock);
            if (reg_reset_request !== 1'b0 || negotiation_restart_request !== 1'b0) begin
                failures++;
                test_done;
            end
            check(phy_control_pkg::PHY_CONTROL_RESET, mgmt_rdata);
        end
        $display("command test done");
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        t_reset;
        t_write;
        t_collision;
        t_commands;
        wr(5'h00, 16'h4C00);
        idle;
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        t_reset;
        test_done;
    end
endmodule

/* tb/phy_control_register_sva.sv */
// Port assertions for the PHY control register
`timescale 1ns/100ps
module phy_control_checker (
    input wire logic                         clock,
    input wire logic                         rst_n,
    input wire logic                         mgmt_write,
    input wire logic [4:0]                   mgmt_addr,
    input wire logic [15:0]                  mgmt_wdata,
    input wire logic                         tx_active,
    input wire logic                         reg_reset_done,
    input wire logic                         negotiation_restart_done,
    input wire logic [15:0]                  mgmt_rdata,
    input wire phy_control_pkg::phy_config_s phy_config,
    input wire logic                         reg_reset_request,
    input wire logic                         negotiation_restart_request,
    input wire logic                         collision_indication
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wire quiet = !reg_reset_done && !negotiation_restart_done; // No completion this cycle
    wire calm = quiet && !reg_reset_request && !negotiation_restart_request; // No command pending
    a_reserved_zero: assert property (mgmt_rdata[6:0] == 7'h00) else $error("reserved bits set");
    a_write_taken: assert property (mgmt_write && mgmt_addr == 5'h00 && calm |=>
        mgmt_rdata == ($past(mgmt_wdata) & 16'hFF80)) else $error("write not stored");
    a_other_ignored: assert property (mgmt_write && mgmt_addr != 5'h00 && quiet |=>
        $stable(mgmt_rdata)) else $error("unmapped write changed register");
    a_config_mirror: assert property (phy_config == {mgmt_rdata[14:10], mgmt_rdata[8:7]})
        else $error("config differs from register");
    a_coll_rise: assert property (phy_config.collision_test_enable && tx_active |=> collision_indication)
        else $error("collision missing");
    a_coll_fall: assert property (!tx_active |=> !collision_indication) else $error("collision stuck");
    a_reset_pending: assert property (reg_reset_request == mgmt_rdata[15]) else $error("reset request wrong");
    a_restart_pending: assert property (negotiation_restart_request == mgmt_rdata[9])
        else $error("restart request wrong");
    a_reset_restores: assert property (reg_reset_request && reg_reset_done && !mgmt_write |=>
        mgmt_rdata == phy_control_pkg::PHY_CONTROL_RESET) else $error("reset value not restored");
    a_restart_clears: assert property (negotiation_restart_done && !reg_reset_done && !mgmt_write |=>
        !negotiation_restart_request) else $error("restart bit not cleared");
    a_reset_held: assert property (reg_reset_request && !reg_reset_done |=> reg_reset_request)
        else $error("reset request dropped early");
    a_restart_held: assert property (negotiation_restart_request && !negotiation_restart_done
        && !reg_reset_done |=> negotiation_restart_request) else $error("restart request dropped early");
endmodule
bind phy_control_register phy_control_checker i_chk (.clock(clock), .rst_n(rst_n), .mgmt_write(mgmt_write),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .tx_active(tx_active), .reg_reset_done(reg_reset_done),
    .negotiation_restart_done(negotiation_restart_done), .mgmt_rdata(mgmt_rdata), .phy_config(phy_config),
    .reg_reset_request(reg_reset_request), .negotiation_restart_request(negotiation_restart_request),
    .collision_indication(collision_indication));

/* tb/phy_core_model.sv */
// PHY core stand-in that finishes register reset and negotiation restart commands
`timescale 1ns/100ps
module phy_core_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic reg_reset_request,
    input  wire logic negotiation_restart_request,
    output logic      reg_reset_done,
    output logic      negotiation_restart_done
);
    logic [7:0] wait_ff;                                       // Cycles spent on the pending command
    wire        fin = wait_ff == (slow ? 8'h14 : 8'h02);       // Command finished, slow or prompt
    wire        busy = reg_reset_request || negotiation_restart_request; // A command is pending
    // Count while a command is pending, restart after each completion
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n) wait_ff <= 8'h00;
        else wait_ff <= (busy && !fin) ? wait_ff + 8'h01 : 8'h00;
    assign reg_reset_done           = reg_reset_request && fin;
    assign negotiation_restart_done = negotiation_restart_request && fin;
endmodule
